// ### wsa_pkg.sv
// Constants and types for the warm-start activation sequencer.
// Assumes a single 100 MHz clock and a symbol strobe from the line timing.
package wsa_pkg;
    localparam longint CLK_HZ = 100_000_000;
    localparam longint MS_PER_S = 1000;
    localparam longint CYC_PER_MS = CLK_HZ / MS_PER_S;
    localparam longint SEC_PER_MIN = 60;
    // Nominal durations in ms (ACTIVE_MIN_MIN in minutes); tolerance is +-2 ms, nominal is used
    localparam longint REMOTE_WAKEUP_MS = 12;
    localparam longint CENTRAL_WAKEUP_MS = 20;
    localparam longint GUARD_GAP_MS = 6;
    localparam longint REMOTE_HDX_MS = 40;
    localparam longint CENTRAL_SEG_MIN_MS = 100;
    localparam longint MAX_ACTIVATION_MS = 500;
    localparam longint ACTIVE_MIN_MIN = 5;
    // Defined elsewhere in the system; plain defaults
    localparam longint SILENCE_DEF_MS = 100;
    localparam longint PAYLOAD_DEF_MS = 10;
    localparam int TW = 40;
    localparam int SW = 9;
    localparam logic [SW-1:0] READY_SYMS = 9'h100;
    localparam int DATA_START_MAX_SYMS = 200;
    localparam logic [3:0] IDX_ZERO = 4'h3;
    localparam logic [3:0] IDX_ONE = 4'h8;
    localparam int SCR_LEN = 23;
    localparam int SCR_TAP = 18;
    localparam logic [SCR_LEN-1:0] SCR_SEED = 23'h000001;
    localparam int SET_W = 32;

    typedef enum logic [9:0] {
        S_IDLE   = 10'h001,
        S_WAKE   = 10'h002,
        S_LISTEN = 10'h004,
        S_GUARD  = 10'h008,
        S_HDX    = 10'h010,
        S_GAP    = 10'h020,
        S_TRAIN  = 10'h040,
        S_READY  = 10'h080,
        S_DATA   = 10'h100,
        S_EXCEPT = 10'h200
    } state_t;

    typedef enum logic [2:0] {
        TX_SILENT = 3'h0,
        TX_TONE_R = 3'h1,
        TX_TONE_C = 3'h2,
        TX_PAM    = 3'h3,
        TX_DATA   = 3'h4
    } tx_kind_t;

    typedef struct packed {
        tx_kind_t kind;
        logic bit_val;
        logic [3:0] index;
    } tx_sym_t;

    typedef struct packed {
        logic far_active;
        logic far_ready;
        logic local_ready;
        logic abnormal;
    } line_ev_t;
endpackage

// ### warm_start_seq.sv
// Warm-start activation sequencer for either end of the loop.
// Assumes line detectors and the symbol strobe are synchronous to MCLK.
module warm_start_seq #(
    parameter logic [wsa_pkg::TW-1:0] T_RWAKE =
        wsa_pkg::TW'(wsa_pkg::REMOTE_WAKEUP_MS * wsa_pkg::CYC_PER_MS),
    parameter logic [wsa_pkg::TW-1:0] T_CWAKE =
        wsa_pkg::TW'(wsa_pkg::CENTRAL_WAKEUP_MS * wsa_pkg::CYC_PER_MS),
    parameter logic [wsa_pkg::TW-1:0] T_GUARD =
        wsa_pkg::TW'(wsa_pkg::GUARD_GAP_MS * wsa_pkg::CYC_PER_MS),
    parameter logic [wsa_pkg::TW-1:0] T_HDX =
        wsa_pkg::TW'(wsa_pkg::REMOTE_HDX_MS * wsa_pkg::CYC_PER_MS),
    parameter logic [wsa_pkg::TW-1:0] T_SEG =
        wsa_pkg::TW'(wsa_pkg::CENTRAL_SEG_MIN_MS * wsa_pkg::CYC_PER_MS),
    parameter logic [wsa_pkg::TW-1:0] T_MAX =
        wsa_pkg::TW'(wsa_pkg::MAX_ACTIVATION_MS * wsa_pkg::CYC_PER_MS),
    parameter logic [wsa_pkg::TW-1:0] T_ACTIVE =
        wsa_pkg::TW'(wsa_pkg::ACTIVE_MIN_MIN * wsa_pkg::SEC_PER_MIN
        * wsa_pkg::MS_PER_S * wsa_pkg::CYC_PER_MS),
    parameter logic [wsa_pkg::TW-1:0] T_SILENCE =
        wsa_pkg::TW'(wsa_pkg::SILENCE_DEF_MS * wsa_pkg::CYC_PER_MS),
    parameter logic [wsa_pkg::TW-1:0] T_PAYLOAD =
        wsa_pkg::TW'(wsa_pkg::PAYLOAD_DEF_MS * wsa_pkg::CYC_PER_MS)
) (
    input wire logic MCLK, // 100 MHz clock
    input wire logic SYS_RST, // Synchronous reset, active high
    input wire logic IS_CENTRAL, // 1 = central-side unit, 0 = remote
    input wire logic START, // Local warm-start request pulse
    input wire logic SYM_TICK, // One pulse per data-mode symbol
    input wire wsa_pkg::line_ev_t LINE_EV, // Line detectors and status
    input wire logic DEACT_REQ, // Deactivation request from link layer
    input wire logic SAVE, // Store settings pulse, honoured in idle or data
    input wire logic [wsa_pkg::SET_W-1:0] SETTINGS_IN, // Settings to store
    output wsa_pkg::tx_sym_t TX, // Transmit signal selection and symbol
    output logic DATA_MODE, // Data-mode frames are being sent
    output logic PAYLOAD_VALID, // Payload data in frames is valid
    output logic COLD_START, // One-cycle pulse: start pre-activation
    output logic DEACT_OK, // Minimum active time has elapsed
    output logic SETTINGS_VALID, // Stored settings usable
    output logic [wsa_pkg::SET_W-1:0] SETTINGS_OUT // Stored settings
);
    wsa_pkg::state_t state_q, state_d;
    logic [wsa_pkg::TW-1:0] tmr_q, act_q, live_q, pay_q;
    logic [wsa_pkg::SW-1:0] sym_q;
    logic [wsa_pkg::SCR_LEN-1:0] scr_q;
    logic seen_q, cold_q, pam, scr_in, timeout, s_bit;

    function automatic logic reached(input logic [wsa_pkg::TW-1:0] t,
                                     input logic [wsa_pkg::TW-1:0] lim);
        reached = ({1'b0, t} + 1'b1) >= {1'b0, lim};
    endfunction

    assign pam = state_q inside {wsa_pkg::S_HDX, wsa_pkg::S_TRAIN,
                                 wsa_pkg::S_READY};
    assign scr_in = (state_q != wsa_pkg::S_READY);
    assign s_bit = scr_in ^ scr_q[wsa_pkg::SCR_TAP-1]
                   ^ scr_q[wsa_pkg::SCR_LEN-1];
    assign timeout = reached(act_q, T_MAX);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            wsa_pkg::S_IDLE: begin
                if (SETTINGS_VALID && START) begin
                    state_d = wsa_pkg::S_WAKE;
                end else if (SETTINGS_VALID && LINE_EV.far_active) begin
                    state_d = IS_CENTRAL ? wsa_pkg::S_WAKE
                                         : wsa_pkg::S_LISTEN;
                end
            end
            wsa_pkg::S_WAKE: begin
                if (reached(tmr_q, IS_CENTRAL ? T_CWAKE : T_RWAKE)) begin
                    state_d = wsa_pkg::S_LISTEN;
                end
            end
            wsa_pkg::S_LISTEN: begin
                if (seen_q && !LINE_EV.far_active) begin
                    state_d = wsa_pkg::S_GUARD;
                end
            end
            wsa_pkg::S_GUARD: begin
                if (reached(tmr_q, T_GUARD)) begin
                    state_d = IS_CENTRAL ? wsa_pkg::S_TRAIN
                                         : wsa_pkg::S_HDX;
                end
            end
            wsa_pkg::S_HDX: begin
                if (reached(tmr_q, T_HDX)) begin
                    state_d = wsa_pkg::S_GAP;
                end
            end
            wsa_pkg::S_GAP: begin
                if (reached(tmr_q, T_GUARD + T_SEG)) begin
                    state_d = wsa_pkg::S_TRAIN;
                end
            end
            wsa_pkg::S_TRAIN: begin
                if (IS_CENTRAL ? (reached(tmr_q, T_SEG) && LINE_EV.local_ready
                                  && LINE_EV.far_ready)
                               : LINE_EV.local_ready) begin
                    state_d = wsa_pkg::S_READY;
                end
            end
            wsa_pkg::S_READY: begin
                if (IS_CENTRAL ? (sym_q == wsa_pkg::READY_SYMS)
                               : (seen_q && !LINE_EV.far_ready)) begin
                    state_d = wsa_pkg::S_DATA;
                end
            end
            wsa_pkg::S_DATA: begin
                if (DEACT_REQ && DEACT_OK) begin
                    state_d = wsa_pkg::S_IDLE;
                end
            end
            wsa_pkg::S_EXCEPT: begin
                if (reached(tmr_q, T_SILENCE) && !LINE_EV.far_active) begin
                    state_d = wsa_pkg::S_IDLE;
                end
            end
        endcase
        if (!(state_q inside {wsa_pkg::S_IDLE, wsa_pkg::S_DATA,
                              wsa_pkg::S_EXCEPT})
            && (timeout || LINE_EV.abnormal)) begin
            state_d = wsa_pkg::S_EXCEPT;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            state_q <= wsa_pkg::S_IDLE;
            tmr_q <= '0;
        end else begin
            state_q <= state_d;
            tmr_q <= (state_d != state_q) ? '0 : tmr_q + 1'b1;
        end
    end

    // Watchdog runs across the whole sequence, not per state
    always_ff @(posedge MCLK) begin
        if (SYS_RST || state_q inside {wsa_pkg::S_IDLE, wsa_pkg::S_DATA,
                                       wsa_pkg::S_EXCEPT}) begin
            act_q <= '0;
        end else begin
            act_q <= act_q + 1'b1;
        end
    end

    // One flag serves both listen and remote ready: far signal seen
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            seen_q <= 1'b0;
        end else if (state_d != state_q) begin
            seen_q <= (state_d == wsa_pkg::S_LISTEN) && LINE_EV.far_active;
        end else if (state_q == wsa_pkg::S_LISTEN && LINE_EV.far_active) begin
            seen_q <= 1'b1;
        end else if (state_q == wsa_pkg::S_READY && LINE_EV.far_ready) begin
            seen_q <= 1'b1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST || state_q != wsa_pkg::S_READY) begin
            sym_q <= '0;
        end else if (SYM_TICK && sym_q != wsa_pkg::READY_SYMS) begin
            sym_q <= sym_q + 1'b1;
        end
    end

    // Scrambler advances one bit per symbol while training or the ready signal is sent
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            scr_q <= wsa_pkg::SCR_SEED;
        end else if (pam && SYM_TICK) begin
            scr_q <= {scr_q[wsa_pkg::SCR_LEN-2:0], s_bit};
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            TX <= '{wsa_pkg::TX_SILENT, 1'b0, wsa_pkg::IDX_ZERO};
        end else begin
            TX.bit_val <= s_bit;
            TX.index <= s_bit ? wsa_pkg::IDX_ONE : wsa_pkg::IDX_ZERO;
            unique case (1'b1)
                state_q == wsa_pkg::S_WAKE:
                    TX.kind <= IS_CENTRAL ? wsa_pkg::TX_TONE_C
                                          : wsa_pkg::TX_TONE_R;
                pam: TX.kind <= wsa_pkg::TX_PAM;
                state_q == wsa_pkg::S_DATA: TX.kind <= wsa_pkg::TX_DATA;
                default: TX.kind <= wsa_pkg::TX_SILENT;
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST || state_q != wsa_pkg::S_DATA) begin
            pay_q <= '0;
            live_q <= '0;
            DATA_MODE <= 1'b0;
            PAYLOAD_VALID <= 1'b0;
            DEACT_OK <= 1'b0;
        end else begin
            DATA_MODE <= 1'b1;
            // Intervals run from the first data symbol on the line, so
            // neither flag can come a cycle early
            if (DATA_MODE && !PAYLOAD_VALID) begin
                pay_q <= pay_q + 1'b1;
            end
            PAYLOAD_VALID <= DATA_MODE && reached(pay_q, T_PAYLOAD);
            if (DATA_MODE && !DEACT_OK) begin
                live_q <= live_q + 1'b1;
            end
            DEACT_OK <= DATA_MODE && reached(live_q, T_ACTIVE);
        end
    end

    // Settings from a good activation feed the next warm-start
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            SETTINGS_VALID <= 1'b0;
            SETTINGS_OUT <= '0;
            cold_q <= 1'b0;
        end else begin
            cold_q <= (state_q == wsa_pkg::S_EXCEPT
                       && state_d == wsa_pkg::S_IDLE)
                      || (state_q == wsa_pkg::S_IDLE && START
                          && !SETTINGS_VALID);
            // A cold-start link runs while this block idles; its settings
            // must be storable too, or no warm-start could ever begin
            if ((state_q == wsa_pkg::S_DATA || state_q == wsa_pkg::S_IDLE)
                && SAVE) begin
                SETTINGS_VALID <= 1'b1;
                SETTINGS_OUT <= SETTINGS_IN;
            end else if (state_q == wsa_pkg::S_EXCEPT) begin
                SETTINGS_VALID <= 1'b0;
            end
        end
    end
    assign COLD_START = cold_q;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    sequence ready_done_s;
        state_q == wsa_pkg::S_READY && IS_CENTRAL
        && state_d == wsa_pkg::S_DATA;
    endsequence
    sequence enter_except_s;
        state_q != wsa_pkg::S_EXCEPT && state_d == wsa_pkg::S_EXCEPT;
    endsequence

    mapper_levels_a: assert property (
        TX.kind == wsa_pkg::TX_PAM |-> TX.index ==
        (TX.bit_val ? wsa_pkg::IDX_ONE : wsa_pkg::IDX_ZERO))
        else $error("mapper index does not match scrambler bit");
    ready_length_a: assert property (
        ready_done_s |-> sym_q == wsa_pkg::READY_SYMS)
        else $error("central ready not 256 symbols");
    data_follows_a: assert property (
        ready_done_s |=> ##1 DATA_MODE && TX.kind == wsa_pkg::TX_DATA)
        else $error("data mode late after ready");
    except_silent_a: assert property (
        enter_except_s |=> ##1 TX.kind == wsa_pkg::TX_SILENT [*2])
        else $error("transmit not silent in exception");
    except_exit_a: assert property (
        state_q == wsa_pkg::S_EXCEPT && state_d == wsa_pkg::S_IDLE
        |-> reached(tmr_q, T_SILENCE) && !LINE_EV.far_active ##1 COLD_START)
        else $error("exception left too early");
    watchdog_a: assert property (
        timeout && !(state_q inside {wsa_pkg::S_IDLE, wsa_pkg::S_DATA,
                                     wsa_pkg::S_EXCEPT})
        |=> state_q == wsa_pkg::S_EXCEPT)
        else $error("timeout did not raise exception");
    deact_gate_a: assert property (
        $rose(DEACT_OK) |-> $past(live_q) + 1'b1 >= T_ACTIVE)
        else $error("deactivation allowed too soon");
    remote_wake_a: assert property (
        state_q == wsa_pkg::S_WAKE && !IS_CENTRAL
        && state_d == wsa_pkg::S_LISTEN |-> tmr_q + 1'b1 == T_RWAKE)
        else $error("remote wake-up tone length wrong");
    gap_len_a: assert property (
        state_q == wsa_pkg::S_GAP && state_d == wsa_pkg::S_TRAIN
        |-> tmr_q + 1'b1 == T_GUARD + T_SEG)
        else $error("full-duplex start offset wrong");
    train_ones_a: assert property (
        state_q inside {wsa_pkg::S_HDX, wsa_pkg::S_TRAIN} |-> scr_in)
        else $error("training not fed with ones");
endmodule

// ### peer_model.sv
// Far-end transceiver model that drives the line detector levels.
// Assumes the device transmit kind is synchronous to MCLK.
module peer_model #(
    parameter int T_CW = 30,
    parameter int T_G = 10,
    parameter int T_H = 40,
    parameter int T_S = 60,
    parameter int T_R = 1024
) (
    input wire logic MCLK, // Clock
    input wire logic SYS_RST, // Synchronous reset
    input wire logic CENTRAL, // 1 = model acts as central unit
    input wire logic INIT, // Pulse: model initiates a warm-start
    input wire logic ABORT, // Model falls silent
    input wire logic [7:0] SLOW, // Extra cycles before ready
    input wire wsa_pkg::tx_kind_t DEV_KIND, // Device transmit kind
    output logic FAR_ACTIVE, // Energy on the line
    output logic FAR_READY // Ready signal on the line
);
    int t;
    int train_at;
    int rdy_at;
    logic run;
    wsa_pkg::tx_kind_t last;
    wire tone_end = !run && DEV_KIND == wsa_pkg::TX_SILENT &&
        (last == wsa_pkg::TX_TONE_R || last == wsa_pkg::TX_TONE_C);
    always_ff @(posedge MCLK) begin
        last <= DEV_KIND;
        if (SYS_RST || ABORT) begin
            run <= 1'b0;
            t <= 0;
        end else if (INIT || tone_end) begin
            run <= 1'b1;
            t <= 0;
        end else if (run) begin
            t <= t + 1;
        end
    end
    assign train_at = CENTRAL ? T_CW + 2 * T_G + T_H
        : 2 * T_G + T_H + T_S;
    assign FAR_ACTIVE = run && ((CENTRAL ? t < T_CW
        : (t >= T_G && t < T_G + T_H)) || t >= train_at);
    // Stands in for the peer's convergence, which is not modelled
    // A central peer answers the remote ready a guard later and sends its
    // own for T_R cycles; a remote peer holds its ready until silenced
    assign rdy_at = train_at + T_S + int'(SLOW) + (CENTRAL ? T_G : 0);
    assign FAR_READY = run && t >= rdy_at
        && (!CENTRAL || t < rdy_at + T_R);
endmodule

// ### warm_start_activation_sequencer_bench.sv
// Self-checking bench for the warm-start sequencer and a far-end model.
// Assumes shortened durations and one symbol tick every four clocks.
module warm_start_activation_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RW = 20, CW = 30, G = 10, H = 40, S = 60;
    localparam int SIL = 50, PL = 25, ACT = 300, LIMIT = 20000;
    logic mclk = 0, sys_rst = 1, is_central = 0, start = 0, tick = 0;
    logic save = 0, deact_req = 0, local_ready = 0, abnormal = 0;
    logic p_init = 0, p_abort = 0, far_active, far_ready;
    logic data_mode, payload_valid, cold_start, deact_ok, set_valid;
    logic [7:0] slow = 0;
    logic [31:0] set_in = 0, set_out;
    wsa_pkg::tx_sym_t tx;
    wsa_pkg::line_ev_t ev;
    int miscompares = 0, samples_checked = 0, cyc = 0, w, n, t0;
    assign ev = {far_active, far_ready, local_ready, abnormal};
    warm_start_seq #(.T_RWAKE(40'(RW)), .T_CWAKE(40'(CW)),
        .T_GUARD(40'(G)), .T_HDX(40'(H)), .T_SEG(40'(S)),
        .T_MAX(40'(3000)), .T_ACTIVE(40'(ACT)), .T_SILENCE(40'(SIL)),
        .T_PAYLOAD(40'(PL))) DUT (.MCLK(mclk), .SYS_RST(sys_rst),
        .IS_CENTRAL(is_central), .START(start), .SYM_TICK(tick),
        .LINE_EV(ev), .DEACT_REQ(deact_req), .SAVE(save),
        .SETTINGS_IN(set_in), .TX(tx), .DATA_MODE(data_mode),
        .PAYLOAD_VALID(payload_valid), .COLD_START(cold_start),
        .DEACT_OK(deact_ok), .SETTINGS_VALID(set_valid),
        .SETTINGS_OUT(set_out));
    peer_model #(.T_CW(CW), .T_G(G), .T_H(H), .T_S(S),
        .T_R(4 * int'(wsa_pkg::READY_SYMS))) peer (
        .MCLK(mclk), .SYS_RST(sys_rst), .CENTRAL(!is_central),
        .INIT(p_init), .ABORT(p_abort), .SLOW(slow), .DEV_KIND(tx.kind),
        .FAR_ACTIVE(far_active), .FAR_READY(far_ready));
    initial begin
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            miscompares++;
            end_of_test();
        end
    end
    always @(negedge mclk) tick <= (cyc % 4 == 0);
    always @(negedge mclk) begin
        if (tx.kind === wsa_pkg::TX_PAM) begin
            check("index", tx.bit_val ? 4'h8 : 4'h3, tx.index);
        end
    end
    task automatic check(string nm, logic [39:0] e, logic [39:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic in_range(string nm, int lo, int hi, int v);
        check(nm, (v >= lo && v <= hi) ? v : lo, v);
    endtask
    // Silent symbol after reset carries the first scrambled training bit
    function automatic logic [7:0] idle_tx();
        logic b;
        b = 1'b1 ^ wsa_pkg::SCR_SEED[wsa_pkg::SCR_TAP-1]
            ^ wsa_pkg::SCR_SEED[wsa_pkg::SCR_LEN-1];
        return {wsa_pkg::TX_SILENT, b,
                b ? wsa_pkg::IDX_ONE : wsa_pkg::IDX_ZERO};
    endfunction
    task automatic step(int k);
        repeat (k) @(negedge mclk);
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        step(1);
        s = 0;
    endtask
    task automatic wait_kind(wsa_pkg::tx_kind_t k, output int c);
        c = 0;
        while (tx.kind !== k && c < 3000) begin
            step(1);
            c++;
        end
    endtask
    task automatic len_kind(wsa_pkg::tx_kind_t k, output int c);
        c = 0;
        while (tx.kind === k) begin
            step(1);
            c++;
        end
    endtask
    task automatic wait_lvl(ref logic s, input logic v, output int c);
        c = 0;
        while (s !== v && c < 3000) begin
            step(1);
            c++;
        end
    endtask
    // Called as the ready signal ends; times count from that point
    task automatic data_phase(string nm);
        t0 = cyc;
        wait_lvl(data_mode, 1, n);
        in_range("start", 0, 800, n);
        check("kind", wsa_pkg::TX_DATA, tx.kind);
        wait_lvl(payload_valid, 1, n);
        in_range("payload", PL, PL + 4, cyc - t0);
        p_abort = 1;
        set_in = $urandom();
        pulse(save);
        deact_req = 1;
        step(3);
        check("hold", 1, data_mode);
        check("saved", set_in, set_out);
        check("valid", 1, set_valid);
        wait_lvl(deact_ok, 1, n);
        in_range("active", ACT, ACT + 5, cyc - t0);
        wait_lvl(data_mode, 0, n);
        in_range("leave", 0, 4, n);
        deact_req = 0;
        local_ready = 0;
        step(5);
        p_abort = 0;
        $display("test %s done", nm);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(32'h09b76e4c));
        step(2);
        sys_rst = 0;
        step(1);
        check("tx", idle_tx(), tx);
        check("flags", 0, {data_mode, cold_start, deact_ok, set_valid});
        pulse(start);
        n = 0;
        repeat (4) begin
            n += cold_start;
            step(1);
        end
        check("refuse", 1, n);
        check("quiet", wsa_pkg::TX_SILENT, tx.kind);
        $display("test refusal done");
        // Settings of a cold-start link are stored while the sequencer idles
        set_in = $urandom();
        pulse(save);
        check("stored", set_in, set_out);
        check("usable", 1, set_valid);
        // Far end opens; the device answers as remote unit
        slow = 8'($urandom_range(40));
        pulse(p_init);
        wait_kind(wsa_pkg::TX_PAM, w);
        in_range("guard", CW + G, CW + G + 4, w);
        len_kind(wsa_pkg::TX_PAM, n);
        check("half", H, n);
        local_ready = 1;
        wait_kind(wsa_pkg::TX_PAM, w);
        check("gap", G + S, w);
        wait_lvl(far_ready, 1, w);
        wait_lvl(far_ready, 0, w);
        check("rready", wsa_pkg::TX_PAM, tx.kind);
        data_phase("remote answer");
        is_central = 1;
        slow = 8'($urandom_range(40));
        pulse(start);
        wait_kind(wsa_pkg::TX_TONE_C, w);
        in_range("wake", 0, 2, w);
        len_kind(wsa_pkg::TX_TONE_C, n);
        check("ctone", CW, n);
        wait_kind(wsa_pkg::TX_PAM, w);
        in_range("cgap", 2 * G + H, 2 * G + H + 4, w);
        wait_lvl(far_ready, 1, w);
        in_range("train", S, 3000, w + 2);
        step(2 + $urandom_range(5));
        local_ready = 1;
        n = 0;
        while (tx.kind === wsa_pkg::TX_PAM && n < 2000) begin
            n += tick;
            step(1);
        end
        in_range("ready", 255, 257, n);
        data_phase("central start");
        is_central = 0;
        pulse(start);
        wait_kind(wsa_pkg::TX_TONE_R, w);
        len_kind(wsa_pkg::TX_TONE_R, n);
        check("rtone", RW, n);
        wait_kind(wsa_pkg::TX_PAM, w);
        step(H / 2);
        pulse(abnormal);
        step(2);
        check("abort", wsa_pkg::TX_SILENT, tx.kind);
        t0 = cyc;
        step(SIL + 20);
        p_abort = 1;
        wait_lvl(cold_start, 1, n);
        in_range("silence", SIL + 20, SIL + 26, cyc - t0);
        step(2);
        check("cleared", 0, set_valid);
        p_abort = 0;
        $display("test exception done");
        end_of_test();
    end
endmodule
